// *** core/bnm_move_unit.sv ***
// apb top of the bit and nibble move unit
// assumes a single clock, synchronous reset, and an apb master on clk
// clkEn low also stalls pready, so the master must be held with it
`timescale 1ns/1ps
module bnm_move_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] dstOut
);
    import bnm_pkg::*;

    // ========================================
    // decode helpers, shared by the write and the read side
    function automatic logic hitOfs(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction

    // registers are 16 bits wide; the upper half of the bus reads zero
    function automatic logic [31:0] widen(
        input logic [15:0] word
    );
        return {16'h0000, word};
    endfunction

    // ========================================
    // registers and their next values
    logic [15:0] srcWord_q;
    logic [15:0] srcWord_d;
    logic [15:0] operand_q;
    logic [15:0] operand_d;
    logic [15:0] dstWord_q;
    logic [15:0] dstWord_d;
    bnm_op_type opSel_q;
    bnm_op_type opSel_d;
    bnm_state_type state_q;
    bnm_state_type state_d;
    logic done_q;
    logic done_d;
    logic ready_d;
    logic err_d;
    logic [31:0] rdata_d;
    logic [15:0] dstOut_d;

    // ========================================
    // bus decode
    logic setup;
    logic wrEn;
    logic selCtrl;
    logic selSrc;
    logic selOpnd;
    logic selDst;
    logic selStat;
    logic mapped;
    logic wrCtrl;
    logic wrSrc;
    logic wrOpnd;
    logic wrDst;
    logic goWrite;
    logic busy;
    logic [15:0] bitResult;
    logic [15:0] nibResult;
    logic [15:0] opResult;

    assign setup = psel && !penable;
    // pready is only high in an access cycle, so this is the commit
    assign wrEn = psel && penable && pready && pwrite;
    assign selCtrl = hitOfs(paddr, BNM_CTRL_OFS);
    assign selSrc = hitOfs(paddr, BNM_SRC_OFS);
    assign selOpnd = hitOfs(paddr, BNM_OPND_OFS);
    assign selDst = hitOfs(paddr, BNM_DST_OFS);
    assign selStat = hitOfs(paddr, BNM_STAT_OFS);
    assign mapped = selCtrl || selSrc || selOpnd || selDst || selStat;
    // an unmapped write selects nothing and so changes nothing
    assign wrCtrl = wrEn && selCtrl;
    assign wrSrc = wrEn && selSrc;
    assign wrOpnd = wrEn && selOpnd;
    assign wrDst = wrEn && selDst;
    assign goWrite = wrCtrl && pwdata[BNM_CTRL_GO_BIT];
    assign busy = (state_q == BNM_EXEC);

    // ========================================
    // the two datapaths, one for each operation

    bnm_bit_copy bitCopy (
        .srcWord(srcWord_q),
        .dstWord(dstWord_q),
        .operand(operand_q),
        .result(bitResult)
    );

    bnm_nibble_copy nibCopy (
        .srcWord(srcWord_q),
        .dstWord(dstWord_q),
        .operand(operand_q),
        .result(nibResult)
    );

    // ========================================
    // result select; both datapaths run all the time
    always_comb begin
        opResult = bitResult; // see RULE_01
        if (opSel_q == BNM_OP_NIBBLE) begin
            opResult = nibResult; // see RULE_09
        end
    end

    // ========================================
    // apb answer: one wait-free access cycle after every setup
    always_comb begin
        ready_d = setup;
    end

    always_comb begin
        err_d = setup && !mapped;
    end

    // read data is latched at setup so it stands through the access cycle
    always_comb begin
        rdata_d = prdata;
        if (setup && !pwrite) begin
            unique case (paddr)
                BNM_CTRL_OFS: rdata_d = {30'h0, opSel_q, 1'b0};
                BNM_SRC_OFS: rdata_d = widen(srcWord_q);
                BNM_OPND_OFS: rdata_d = widen(operand_q);
                BNM_DST_OFS: rdata_d = widen(dstWord_q);
                BNM_STAT_OFS: rdata_d = {30'h0, done_q, busy};
                default: rdata_d = BNM_RDATA_RST;
            endcase
        end
    end

    // ========================================
    // bus answer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else if (clkEn) begin
            pready <= ready_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pslverr <= err_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= BNM_RDATA_RST;
        end else if (clkEn) begin
            prdata <= rdata_d;
        end
    end

    // ========================================
    // operand registers; a constant source is just its 16-bit image
    always_comb begin
        srcWord_d = srcWord_q;
        if (wrSrc) begin
            srcWord_d = pwdata[15:0]; // see RULE_06
        end
    end

    always_comb begin
        operand_d = operand_q;
        if (wrOpnd) begin
            operand_d = pwdata[15:0];
        end
    end

    // op select rides on the same write that carries go
    always_comb begin
        opSel_d = opSel_q;
        if (wrCtrl) begin
            opSel_d = bnm_op_type'(pwdata[BNM_CTRL_OP_BIT]);
        end
    end

    // ========================================
    // operand register updates
    always_ff @(posedge clk) begin
        if (reset) begin
            srcWord_q <= BNM_WORD_RST;
        end else if (clkEn) begin
            srcWord_q <= srcWord_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            operand_q <= BNM_WORD_RST;
        end else if (clkEn) begin
            operand_q <= operand_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            opSel_q <= BNM_OP_BIT;
        end else if (clkEn) begin
            opSel_q <= opSel_d;
        end
    end

    // ========================================
    // trigger: execute one cycle after go so the new op select is seen
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BNM_IDLE: begin
                if (goWrite) begin
                    state_d = BNM_EXEC;
                end
            end
            BNM_EXEC: begin
                // a go in the execute cycle queues one more execute
                if (!goWrite) begin
                    state_d = BNM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= BNM_IDLE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // ========================================
    // destination word: an execute wins over a software write
    always_comb begin
        dstWord_d = dstWord_q;
        if (busy) begin
            dstWord_d = opResult;
        end else if (wrDst) begin
            dstWord_d = pwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dstWord_q <= BNM_WORD_RST;
        end else if (clkEn) begin
            dstWord_q <= dstWord_d;
        end
    end

    // ========================================
    // done is sticky until the next go; completion wins over the clear
    always_comb begin
        done_d = done_q;
        if (busy) begin
            done_d = 1'b1;
        end else if (goWrite) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else if (clkEn) begin
            done_q <= done_d;
        end
    end

    // ========================================
    // output copy, one cycle behind the destination register
    assign dstOut_d = dstWord_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            dstOut <= BNM_WORD_RST;
        end else if (clkEn) begin
            dstOut <= dstOut_d;
        end
    end
endmodule // bnm_move_unit

// *** core/bnm_pkg.sv ***
// package for the bit and nibble move unit: register map, fields, resets
// assumes an apb slave on a 20 MHz clock with 32-bit data
//
// Functional notes
// RULE_01: on trigger, bit move copies one source bit to one destination bit
// RULE_02: control bits 0 to 3 pick the source bit, 0 through 15
// RULE_03: control bits 8 to 11 pick the destination bit, 0 through 15
// RULE_04: bit move ignores control bits 12 to 15
// RULE_05: bit move ignores control bits 4 to 7
// RULE_06: an immediate source is used as its 16-bit binary value
// RULE_07: bit move leaves every other destination bit unchanged
// RULE_08: digit move sees each word as four nibbles, digit 0 lowest
// RULE_09: digit move copies chosen source digits to chosen destination digits
// RULE_10: control nibble 0 picks the first source digit, 0 through 3
// RULE_11: control nibble 1 sets count: 0..3 move one to four digits
// RULE_12: control nibble 2 picks the first destination digit, 0 through 3
// RULE_13: digit control decodes nibble 0 source, 1 count, 2 destination
// RULE_14: untouched digits keep value; digit positions wrap from 3 to 0
package bnm_pkg;
    // ========================================
    // register offsets (byte addresses)
    localparam logic [7:0] BNM_CTRL_OFS = 8'h00;
    localparam logic [7:0] BNM_SRC_OFS = 8'h04;
    localparam logic [7:0] BNM_OPND_OFS = 8'h08;
    localparam logic [7:0] BNM_DST_OFS = 8'h0C;
    localparam logic [7:0] BNM_STAT_OFS = 8'h10;
    // ========================================
    // control and status register fields
    localparam int BNM_CTRL_GO_BIT = 0;
    localparam int BNM_CTRL_OP_BIT = 1;
    localparam int BNM_STAT_BUSY_BIT = 0;
    localparam int BNM_STAT_DONE_BIT = 1;
    // ========================================
    // operand fields
    localparam int BNM_SRC_POS_LSB = 0;
    localparam int BNM_DST_POS_LSB = 8;
    localparam int BNM_CNT_LSB = 4;
    // ========================================
    // reset values
    localparam logic [15:0] BNM_WORD_RST = 16'h0000;
    localparam logic [31:0] BNM_RDATA_RST = 32'h0000_0000;

    typedef enum logic {
        BNM_OP_BIT,
        BNM_OP_NIBBLE
    } bnm_op_type;

    typedef enum {
        BNM_IDLE,
        BNM_EXEC
    } bnm_state_type;
endpackage

// *** core/bnm_bit_copy.sv ***
// single bit copy datapath, purely combinational
// assumes caller registers the result
`timescale 1ns/1ps
module bnm_bit_copy (
    input wire logic [15:0] srcWord,
    input wire logic [15:0] dstWord,
    input wire logic [15:0] operand,
    output logic [15:0] result
);
    import bnm_pkg::*;
    logic [3:0] srcPos;
    logic [3:0] dstPos;
    // upper nibble and nibble 1 never reach the mux
    assign srcPos = operand[BNM_SRC_POS_LSB +: 4]; // see RULE_02 see RULE_05
    assign dstPos = operand[BNM_DST_POS_LSB +: 4]; // see RULE_03 see RULE_04
    always_comb begin
        result = dstWord; // see RULE_07
        result[dstPos] = srcWord[srcPos]; // see RULE_01 see RULE_06
    end
endmodule // bnm_bit_copy

// *** core/bnm_nibble_copy.sv ***
// nibble copy datapath, purely combinational
// assumes caller registers the result
`timescale 1ns/1ps
module bnm_nibble_copy (
    input wire logic [15:0] srcWord,
    input wire logic [15:0] dstWord,
    input wire logic [15:0] operand,
    output logic [15:0] result
);
    import bnm_pkg::*;
    logic [1:0] srcStart;
    logic [1:0] count;
    logic [1:0] dstStart;
    // only the low two bits of each nibble matter, values stop at 3
    assign srcStart = operand[BNM_SRC_POS_LSB +: 2]; // see RULE_10 see RULE_13
    assign count = operand[BNM_CNT_LSB +: 2]; // see RULE_11 see RULE_13
    assign dstStart = operand[BNM_DST_POS_LSB +: 2]; // see RULE_12 see RULE_13
    always_comb begin
        logic [1:0] s;
        logic [1:0] d;
        s = 2'h0;
        d = 2'h0;
        result = dstWord; // see RULE_14
        for (int i = 0; i < 4; i++) begin
            s = 2'(srcStart + 2'(i)); // see RULE_14
            d = 2'(dstStart + 2'(i));
            if (2'(i) <= count) begin
                result[d*4 +: 4] = srcWord[s*4 +: 4]; // see RULE_08 see RULE_09
            end
        end
    end
endmodule // bnm_nibble_copy

// *** tb/bnm_move_unit_chk.sv ***
// checker for the move unit apb top
// assumes it is bound to bnm_move_unit, sees only its ports
`timescale 1ns/1ps
module bnm_move_unit_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] dstOut
);
    import bnm_pkg::*;
    // =========
    // shadows of written operands, expected results
    logic [15:0] srcS, opS, dstS, expB, expN;
    logic [1:0] ss, ds;
    logic wr, goB, goN;
    assign wr = psel && penable && pwrite && pready;
    assign goB = wr && paddr == BNM_CTRL_OFS && pwdata[1:0] == 2'h1;
    assign goN = wr && paddr == BNM_CTRL_OFS && pwdata[1:0] == 2'h3;
    always_ff @(posedge clk) begin
        if (wr && paddr == BNM_SRC_OFS) srcS <= pwdata[15:0];
        if (wr && paddr == BNM_OPND_OFS) opS <= pwdata[15:0];
        if (wr && paddr == BNM_DST_OFS) dstS <= pwdata[15:0];
    end
    // 2-bit positions so digit numbers wrap from 3 to 0
    always_comb begin
        expB = dstS;
        expB[opS[11:8]] = srcS[opS[3:0]];
        expN = dstS;
        for (int i = 0; i < 4; i++) begin
            ss = opS[1:0] + 2'(i);
            ds = opS[9:8] + 2'(i);
            if (i <= int'(opS[5:4])) expN[4*ds +: 4] = srcS[4*ss +: 4];
        end
    end
    // =========
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    AST_BIT: assert property (goB |-> ##3 dstOut == $past(expB, 3))
        else $error("bit copy result wrong");
    AST_NIB: assert property (goN |-> ##3 dstOut == $past(expN, 3))
        else $error("digit copy result wrong");
    AST_QUIET: assert property ($changed(dstOut) |->
        $past(wr, 2) || $past(wr, 3)) else $error("result moved untriggered");
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_PULSE: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready not a single access pulse");
    AST_UNMAP: assert property (psel && penable && paddr > BNM_STAT_OFS
        |-> pslverr) else $error("unmapped access not flagged");
    AST_ERRZ: assert property (pslverr |-> pready && (pwrite || prdata == 0))
        else $error("error answer malformed");
    AST_UPPER: assert property (pready && !pwrite |-> prdata[31:16] == 0)
        else $error("upper read bits not zero");
    AST_RST: assert property ($fell(reset) |-> dstOut == 0 && !pready)
        else $error("outputs not clear after reset");
    COV_BIT: cover property (goB);
    COV_NIB: cover property (goN);
    COV_ERR: cover property (pslverr);
endmodule // bnm_move_unit_chk

bind bnm_move_unit bnm_move_unit_chk chk (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dstOut);

// *** tb/bnm_seq_model.sv ***
// sequencer model: apb master handing operands and the trigger
// assumes clk is the unit clock; the bench calls xfer after reset
`timescale 1ns/1ps
module bnm_seq_model (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    logic lastErr;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // =========
    // one transfer; ready and read data taken at the same rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // no fixed wait assumed; only the bench timeout ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look valid
        pwdata <= ~pwdata;
    endtask
endmodule // bnm_seq_model

// *** tb/testbench.sv ***
// self-checking bench for the move unit
// assumes bnm_seq_model as bus master, clk at 20 MHz
`timescale 1ns/1ps
module testbench;
    import bnm_pkg::*;
    typedef struct {logic op; logic [15:0] s, n, d, e;} bnm_row_type;
    logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] dstOut;
    int failures = 0, samples_checked = 0, cycles = 0;
    bnm_row_type rows [8] = '{
        '{1'b0, 16'h8888, 16'h0F02, 16'hFFFF, 16'h7FFF},
        '{1'b0, 16'h0002, 16'hFCF1, 16'h0000, 16'h1000},
        '{1'b0, 16'h8000, 16'h000F, 16'h1234, 16'h1235},
        '{1'b1, 16'h0149, 16'h0111, 16'h0000, 16'h0140},
        '{1'b1, 16'hABCD, 16'h0003, 16'h1234, 16'h123A},
        '{1'b1, 16'hABCD, 16'h0310, 16'h0000, 16'hD00C},
        '{1'b1, 16'hABCD, 16'h0230, 16'h5555, 16'hCDAB},
        '{1'b1, 16'hABCD, 16'h0121, 16'h5555, 16'hABC5}};
    always #25 clk = ~clk;
    bnm_move_unit dut (.clk, .reset, .clkEn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .dstOut);
    bnm_seq_model seq (.clk, .prdata, .pready, .pslverr, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    // =========
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(input bnm_row_type r);
        int k;
        seq.xfer(1'b1, BNM_SRC_OFS, r.s, q);
        seq.xfer(1'b1, BNM_OPND_OFS, r.n, q);
        seq.xfer(1'b1, BNM_DST_OFS, r.d, q);
        seq.xfer(1'b1, BNM_CTRL_OFS, {14'h0000, r.op, 1'b1}, q);
        k = 0;
        do begin
            seq.xfer(1'b0, BNM_STAT_OFS, 16'h0000, q);
            k++;
        end while (q[BNM_STAT_DONE_BIT] !== 1'b1 && k < 20);
        check(q, 32'h0000_0002);
        seq.xfer(1'b0, BNM_DST_OFS, 16'h0000, q);
        check(q, {16'h0000, r.e});
        check({16'h0000, dstOut}, {16'h0000, r.e});
        $display("row done %h", r.n);
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        seq.xfer(1'b0, BNM_STAT_OFS, 16'h0000, q);
        check(q | dstOut, 32'h0000_0000);
        $display("reset done");
        foreach (rows[i]) run(rows[i]);
        // refused write must leave the last result alone
        seq.xfer(1'b1, 8'h20, 16'hFFFF, q);
        check(seq.lastErr, 32'h0000_0001);
        seq.xfer(1'b0, 8'h20, 16'h0000, q);
        check(q, 32'h0000_0000);
        seq.xfer(1'b0, BNM_DST_OFS, 16'h0000, q);
        check(q, 32'h0000_ABC5);
        seq.xfer(1'b0, BNM_CTRL_OFS, 16'h0000, q);
        check(q[0], 32'h0000_0000);
        $display("unmapped done");
        // reset in mid-run must clear the last result
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        seq.xfer(1'b0, BNM_DST_OFS, 16'h0000, q);
        check(q | dstOut, 32'h0000_0000);
        $display("second reset done");
        give_verdict();
    end
endmodule // testbench
